// ===== design/adc_link_consts.svh
// offsets, field positions and timing counts of the two-wire adc link controller
// Contract
// (RULE1) The driver of SDA keeps it steady while SCL is high.
// (RULE2) An idle bus has SDA and SCL both released high.
// (RULE3) START is SDA falling while SCL is high.
// (RULE4) STOP is SDA rising while SCL is high; it ends the transfer.
// (RULE5) Repeated START keeps the bus active and the speed mode unchanged.
// (RULE6) Acknowledge: receiver pulls SDA low before and through the ninth high phase.
// (RULE7) Not-acknowledge: receiver leaves SDA released through the ninth high phase.
// (RULE8) A missing acknowledge makes the master abandon the transfer and retry later; the controller sends STOP and sets the abandon flag but never retries.
// (RULE9) The idle device waits for START plus its own address before responding.
// (RULE10) The device matches a fixed seven-bit address, set per variant.
// (RULE11) Address byte bit eight: 0 means write, 1 means read.
// (RULE12) The device acknowledges its matched address for one clock.
// (RULE13) After power-up the device runs fast/standard timing.
// (RULE14) Master code 0000_1xxx is not-acknowledged, then high-speed mode starts.
// (RULE15) After that not-acknowledge, master sends repeated START and the address.
// (RULE16) Any STOP returns the device from high-speed to fast/standard mode.
// (RULE17) Written byte MSB 1 loads setup, 0 loads configuration.
// (RULE18) One or two bytes per write cycle, each acknowledged by the device.
// (RULE19) A write cycle ends with STOP or repeated START.
// (RULE20) Setup bit 1 cleared restores configuration defaults.
// (RULE21) Setup bit 0 is ignored.
// (RULE22) Setup bits 6..4 pick reference, bit 3 picks clock; reset zero.
// (RULE23) Setup bit 2 picks bipolar coding; reset zero.
`ifndef ADC_LINK_CONSTS_SVH
`define ADC_LINK_CONSTS_SVH

`define OFS_CMD        32'h0000_0000
`define OFS_STATUS     32'h0000_0004

`define CMD_START      0
`define CMD_WRITE      1
`define CMD_READ       2
`define CMD_STOP       3
`define CMD_HS         4
`define CMD_NACK       5
`define CMD_DATA_LSB   8

`define STS_BUSY       0
`define STS_NACK       1
`define STS_ACTIVE     2
`define STS_HS         3
`define STS_ABANDON    4
`define STS_RX_LSB     8

`define MASTER_CODE    8'h08

`define CLK_NS         5
`define FS_PERIOD_NS   2500
`define HS_PERIOD_NS   588
`define FS_QTR_CYC     8'((`FS_PERIOD_NS + 4 * `CLK_NS - 1) / (4 * `CLK_NS))
`define HS_QTR_CYC     8'((`HS_PERIOD_NS + 4 * `CLK_NS - 1) / (4 * `CLK_NS))

`endif

// ===== design/adc_link_pkg.sv
// types of the two-wire adc link controller
package adc_link_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_SHIFT, ST_STOP} link_state_e;
  typedef enum logic [1:0] {KIND_WRITE, KIND_READ, KIND_MCODE} byte_kind_e;
endpackage

// ===== design/pin_sync.sv
// three-stage synchroniser with agreement filter for the bus pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input  wire logic       hclk,     // system clock
  input  wire logic       hresetn,  // async reset, active low
  input  wire logic [1:0] pin_i,    // raw pin levels
  output logic      [1:0] pin_f     // filtered levels
);
  logic [1:0] s1_q, s2_q, s3_q, f_q;
  logic [1:0] f_d;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
      f_q  <= 2'h3;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  assign pin_f = f_q;
endmodule // pin_sync
`default_nettype wire

// ===== design/adc_link_master.sv
// two-wire bus master for the adc setup port, driven from ahb-lite registers
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "adc_link_consts.svh"
module adc_link_master
  import adc_link_pkg::*;
(
  input  wire logic        hclk,       // system clock, 200 MHz
  input  wire logic        hresetn,    // async reset, active low
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write when high
  input  wire logic [2:0]  hsize,      // word only
  input  wire logic [31:0] hwdata,     // write data
  input  wire logic        hready,     // bus ready
  output logic             hreadyout,  // never stalls
  output logic             hresp,      // always okay
  output logic      [31:0] hrdata,     // read data
  input  wire logic        scl_i,      // clock line level
  output logic             scl_o,      // clock line drive value
  output logic             scl_oe,     // pull clock line low
  input  wire logic        sda_i,      // data line level
  output logic             sda_o,      // data line drive value
  output logic             sda_oe      // pull data line low
);
  // ---------------- bus slave ----------------
  logic        dp_wr_q, dp_wr_d;
  logic [31:0] dp_addr_q, dp_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [31:0] status_w;

  // ---------------- link engine ----------------
  link_state_e st_q, st_d;
  byte_kind_e  kind_q, kind_d;
  logic [6:0]  pend_q, pend_d;
  logic [7:0]  data_q, data_d;
  logic        nack_cmd_q, nack_cmd_d;
  logic [1:0]  ph_q, ph_d;
  logic [7:0]  qcnt_q, qcnt_d;
  logic [3:0]  bit_q, bit_d;
  logic [8:0]  sh_q, sh_d;
  logic [8:0]  smp_q, smp_d;
  logic [7:0]  rx_q, rx_d;
  logic        scl_oe_q, scl_oe_d;
  logic        sda_oe_q, sda_oe_d;
  logic        active_q, active_d;
  logic        hs_q, hs_d;
  logic        nack_q, nack_d;
  logic        aband_q, aband_d;

  logic [1:0]  pin_f;
  logic        scl_f, sda_f;
  logic [7:0]  qlen;
  logic        stall, tick;
  logic        wr_cmd, wr_sts, busy;
  logic [2:0]  pick;

  pin_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_i   ({scl_i, sda_i}),
    .pin_f   (pin_f)
  );
  assign scl_f = pin_f[1];
  assign sda_f = pin_f[0];

  assign busy = (st_q != ST_IDLE) || (pend_q != 7'h00);

  always_comb begin
    status_w                = 32'h0000_0000;
    status_w[`STS_BUSY]     = busy;
    status_w[`STS_NACK]     = nack_q;
    status_w[`STS_ACTIVE]   = active_q;
    status_w[`STS_HS]       = hs_q;
    status_w[`STS_ABANDON]  = aband_q;
    status_w[`STS_RX_LSB +: 8] = rx_q;
  end

  always_comb begin
    dp_wr_d   = 1'b0;
    dp_addr_d = dp_addr_q;
    hrdata_d  = hrdata_q;
    if (hready) begin
      dp_wr_d = hsel && htrans[1] && hwrite;
      if (hsel && htrans[1]) begin
        dp_addr_d = haddr;
        hrdata_d  = 32'h0000_0000;
        if (!hwrite && haddr == `OFS_STATUS) begin
          hrdata_d = status_w;
        end else if (!hwrite && haddr == `OFS_CMD) begin
          hrdata_d[`CMD_DATA_LSB +: 8] = data_q;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 32'h0000_0000;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      dp_wr_q   <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      hrdata_q  <= hrdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  assign wr_cmd = dp_wr_q && (dp_addr_q == `OFS_CMD);
  assign wr_sts = dp_wr_q && (dp_addr_q == `OFS_STATUS);
  assign qlen   = hs_q ? `HS_QTR_CYC : `FS_QTR_CYC;
  // a released clock line that still reads low is being held by the device
  assign stall  = !scl_oe_q && !scl_f;
  assign tick   = (st_q != ST_IDLE) && !stall && (qcnt_q == qlen - 8'd1);

  always_comb begin
    pick = 3'd7;
    for (int i = 6; i >= 0; i--) begin
      if (pend_q[i]) pick = 3'(i);
    end
  end

  always_comb begin
    st_d       = st_q;
    kind_d     = kind_q;
    pend_d     = pend_q;
    data_d     = data_q;
    nack_cmd_d = nack_cmd_q;
    ph_d       = ph_q;
    qcnt_d     = qcnt_q;
    bit_d      = bit_q;
    sh_d       = sh_q;
    smp_d      = smp_q;
    rx_d       = rx_q;
    scl_oe_d   = scl_oe_q;
    sda_oe_d   = sda_oe_q;
    active_d   = active_q;
    hs_d       = hs_q;
    nack_d     = nack_q;
    aband_d    = aband_q;

    if (wr_sts && hwdata[`STS_NACK]) nack_d = 1'b0;
    if (wr_sts && hwdata[`STS_ABANDON]) aband_d = 1'b0;

    // commands are taken only while idle; others are dropped
    if (wr_cmd && !busy) begin
      data_d     = hwdata[`CMD_DATA_LSB +: 8];
      nack_cmd_d = hwdata[`CMD_NACK];
      pend_d     = {hwdata[`CMD_STOP], hwdata[`CMD_READ], hwdata[`CMD_WRITE],
                    hwdata[`CMD_START], {3{hwdata[`CMD_HS]}}};
    end

    if (st_d != ST_IDLE && !stall) begin
      qcnt_d = tick ? 8'd0 : qcnt_q + 8'd1;
    end

    unique case (st_q)
      ST_IDLE: begin
        if (pend_q != 7'h00) begin
          pend_d[pick] = 1'b0;
          ph_d   = 2'd0;
          qcnt_d = 8'd0;
          bit_d  = 4'd0;
          case (pick)
            3'd0, 3'd2, 3'd3: begin // RULE15 RULE19
              st_d     = ST_START;
              scl_oe_d = active_q;
              sda_oe_d = 1'b0;
            end
            3'd1: begin
              st_d     = ST_SHIFT;
              kind_d   = KIND_MCODE;
              sh_d     = {`MASTER_CODE, 1'b1};
              scl_oe_d = 1'b1;
            end
            3'd4: begin
              st_d     = ST_SHIFT;
              kind_d   = KIND_WRITE;
              sh_d     = {data_q, 1'b1};
              scl_oe_d = 1'b1;
            end
            3'd5: begin
              st_d     = ST_SHIFT;
              kind_d   = KIND_READ;
              sh_d     = {8'hFF, nack_cmd_q}; // RULE6 RULE7
              scl_oe_d = 1'b1;
            end
            default: begin
              // a stop on an idle bus has nothing to close
              if (active_q) begin
                st_d     = ST_STOP;
                scl_oe_d = 1'b1;
                sda_oe_d = 1'b1;
              end
            end
          endcase
        end
      end
      ST_START: begin
        if (tick) begin
          ph_d = ph_q + 2'd1;
          unique case (ph_q)
            2'd0: scl_oe_d = 1'b0;
            2'd1: sda_oe_d = 1'b1; // RULE3
            2'd2: scl_oe_d = 1'b1;
            2'd3: begin
              st_d     = ST_IDLE;
              active_d = 1'b1; // RULE5
            end
          endcase
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          ph_d = ph_q + 2'd1;
          unique case (ph_q)
            2'd0: sda_oe_d = !sh_q[8]; // RULE1
            2'd1: scl_oe_d = 1'b0;
            2'd2: smp_d    = {smp_q[7:0], sda_f};
            2'd3: begin
              scl_oe_d = 1'b1;
              sh_d     = {sh_q[7:0], 1'b1};
              bit_d    = bit_q + 4'd1;
              if (bit_q == 4'd8) begin
                st_d = ST_IDLE;
                if (kind_q == KIND_READ) begin
                  rx_d = smp_q[8:1];
                end else if ((kind_q == KIND_MCODE) == smp_q[0]) begin // RULE18
                  if (kind_q == KIND_MCODE) hs_d = 1'b1; // RULE14
                end else begin
                  nack_d  = 1'b1;
                  aband_d = 1'b1;
                  pend_d  = 7'h40; // RULE8
                end
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          ph_d = ph_q + 2'd1;
          unique case (ph_q)
            2'd0: scl_oe_d = 1'b0;
            2'd1: sda_oe_d = 1'b0; // RULE4
            2'd2: ;
            2'd3: begin
              st_d     = ST_IDLE;
              active_d = 1'b0;
              hs_d     = 1'b0; // RULE16
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= ST_IDLE;
      kind_q     <= KIND_WRITE;
      pend_q     <= 7'h00;
      data_q     <= 8'h00;
      nack_cmd_q <= 1'b0;
      ph_q       <= 2'd0;
      qcnt_q     <= 8'd0;
      bit_q      <= 4'd0;
      sh_q       <= 9'h1FF;
      smp_q      <= 9'h000;
      rx_q       <= 8'h00;
      scl_oe_q   <= 1'b0; // RULE2
      sda_oe_q   <= 1'b0; // RULE2
      active_q   <= 1'b0;
      hs_q       <= 1'b0;
      nack_q     <= 1'b0;
      aband_q    <= 1'b0;
    end else begin
      st_q       <= st_d;
      kind_q     <= kind_d;
      pend_q     <= pend_d;
      data_q     <= data_d;
      nack_cmd_q <= nack_cmd_d;
      ph_q       <= ph_d;
      qcnt_q     <= qcnt_d;
      bit_q      <= bit_d;
      sh_q       <= sh_d;
      smp_q      <= smp_d;
      rx_q       <= rx_d;
      scl_oe_q   <= scl_oe_d;
      sda_oe_q   <= sda_oe_d;
      active_q   <= active_d;
      hs_q       <= hs_d;
      nack_q     <= nack_d;
      aband_q    <= aband_d;
    end
  end

  // open drain: only ever pull low
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_idle_release: assert property (st_q == ST_IDLE && !active_q |-> !scl_oe_q && !sda_oe_q) // RULE2
    else $error("idle bus not released");
  a_data_stable: assert property (st_q == ST_SHIFT && $changed(sda_oe_q) |-> $past(scl_oe_q) && scl_oe_q) // RULE1
    else $error("data moved while clock released");
  a_start_edge: assert property ($rose(sda_oe_q) && !scl_oe_q |-> st_q == ST_START ##1 active_q || st_q == ST_START) // RULE3
    else $error("data fell with clock high outside start");
  a_stop_edge: assert property ($fell(sda_oe_q) && !scl_oe_q |-> st_q == ST_STOP ##[1:600] !active_q) // RULE4
    else $error("stop did not end the transfer");
  a_rs_keep_hs: assert property ($fell(hs_q) |-> $past(st_q) == ST_STOP) // RULE5
    else $error("speed mode dropped outside a stop");
  a_read_ack: assert property (st_q == ST_SHIFT && kind_q == KIND_READ && bit_q == 4'd8 && ph_q == 2'd2 && !nack_cmd_q |-> sda_oe_q) // RULE6
    else $error("ack not held in ninth high phase");
  a_read_nack: assert property (st_q == ST_SHIFT && kind_q == KIND_READ && bit_q == 4'd8 && ph_q == 2'd2 && nack_cmd_q |-> !sda_oe_q) // RULE7
    else $error("nack not released in ninth high phase");
  a_nack_abandon: assert property ($rose(aband_q) |-> ##[1:1000] st_q == ST_STOP) // RULE8
    else $error("missing ack not followed by stop");
  a_mcode_hs: assert property ($rose(hs_q) |-> $past(kind_q) == KIND_MCODE && $past(smp_q[0])) // RULE14
    else $error("high speed entered without master code nack");
  a_hs_restart: assert property ($rose(hs_q) |-> ##[1:20] st_q == ST_START) // RULE15
    else $error("no repeated start after master code");
  a_stop_fs: assert property ($fell(active_q) |-> !hs_q) // RULE16
    else $error("high speed kept after stop");

  c_hs_entry: cover property ($rose(hs_q));
  c_abandon: cover property ($rose(aband_q));
  c_read_byte: cover property (st_q == ST_SHIFT && kind_q == KIND_READ ##1 st_q == ST_IDLE);
  c_stretch: cover property (st_q == ST_SHIFT && stall [*4]);
endmodule // adc_link_master
`default_nettype wire

// ===== verif/adc_dev_model.sv
// behavioural model of the adc two-wire setup port
`timescale 1ns/100ps
`default_nettype none
module adc_dev_model #(
  parameter logic [6:0] DEV_ADDR = 7'h5a  // arbitrary value
) (
  input  wire logic scl,    // clock line level
  input  wire logic sda,    // data line level
  output logic      sda_oe  // pull data line low
);
  logic [7:0] sh_q;
  logic [7:0] setup_q;
  logic [7:0] config_q;
  logic       act_q;
  logic       first_q;
  logic       wr_q;
  logic       hs_q;
  int         cnt;
  initial begin
    sda_oe   = 1'b0;
    setup_q  = 8'h00;
    config_q = 8'h01;
    hs_q     = 1'b0;
    act_q    = 1'b0;
    first_q  = 1'b0;
    wr_q     = 1'b0;
    sh_q     = 8'h00;
    cnt      = 0;
  end
  always @(negedge sda) if (scl) begin
    act_q   = 1'b1;
    first_q = 1'b1;
    cnt     = 0;
  end
  always @(posedge sda) if (scl) begin
    act_q = 1'b0;
    hs_q  = 1'b0;
  end
  always @(posedge scl) begin
    if (act_q && cnt < 8) begin
      sh_q = {sh_q[6:0], sda};
      cnt++;
    end else if (act_q && cnt == 9 && !first_q && !wr_q && sda) begin
      act_q = 1'b0;
    end
  end
  always @(negedge scl) if (act_q) begin
    if (cnt == 8) begin
      cnt    = 9;
      sda_oe = 1'b0;
      if (first_q && sh_q[7:1] == DEV_ADDR) begin
        sda_oe  = 1'b1;
        wr_q    = !sh_q[0];
        first_q = 1'b0;
      end else if (first_q && sh_q[7:3] == 5'h01) begin
        hs_q = 1'b1;
      end else if (first_q) begin
        act_q = 1'b0;
      end else if (wr_q) begin
        sda_oe = 1'b1;
        if (sh_q[7]) setup_q = sh_q;
        else config_q = sh_q;
        if (sh_q[7] && !sh_q[1]) config_q = 8'h01;
      end
    end else if (cnt == 9) begin
      cnt    = 0;
      sda_oe = !first_q && !wr_q && !setup_q[7];
    end else if (!first_q && !wr_q) begin
      sda_oe = !setup_q[3'(7 - cnt)];
    end
  end
endmodule  // adc_dev_model
`default_nettype wire

// ===== verif/adc_link_master_tb.sv
// self-checking bench of the two-wire adc link controller
`timescale 1ns/100ps
`default_nettype none
`include "adc_link_consts.svh"
module adc_link_master_tb;
  localparam logic [6:0]  DEV_ADDR = 7'h5a;  // arbitrary value
  localparam logic [31:0] OP_S = 32'h0000_0001 << `CMD_START;
  localparam logic [31:0] OP_W = 32'h0000_0001 << `CMD_WRITE;
  localparam logic [31:0] OP_R = 32'h0000_0001 << `CMD_READ;
  localparam logic [31:0] OP_P = 32'h0000_0001 << `CMD_STOP;
  localparam logic [31:0] OP_H = 32'h0000_0001 << `CMD_HS;
  localparam logic [31:0] OP_N = 32'h0000_0001 << `CMD_NACK;
  localparam logic [31:0] SB_NK = 32'h0000_0001 << `STS_NACK;
  localparam logic [31:0] SB_AC = 32'h0000_0001 << `STS_ACTIVE;
  localparam logic [31:0] SB_HS = 32'h0000_0001 << `STS_HS;
  localparam logic [31:0] SB_AB = 32'h0000_0001 << `STS_ABANDON;
  localparam logic [7:0]  AW = {DEV_ADDR, 1'b0};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, dev_oe;
  logic [31:0] hrdata;
  logic [31:0] s;
  wire  logic  scl = !scl_oe;
  wire  logic  sda = !(sda_oe || dev_oe);
  int          n_errors = 0;
  int          compares = 0;

  always #2.5 hclk = ~hclk;

  adc_link_master u_adc_link_master (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  adc_dev_model #(.DEV_ADDR(DEV_ADDR)) u_adc_dev_model (
    .scl(scl), .sda(sda), .sda_oe(dev_oe));

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // status flags: busy, nack, active, hs and abandon
  task automatic cks(input logic [31:0] exp);
    chk(s & 32'h0000_001f, exp);
  endtask

  // device side: hs flag, setup and configuration contents
  task automatic ckd(input logic h, input logic [7:0] se, input logic [7:0] ce);
    chk({15'h0, u_adc_dev_model.hs_q, u_adc_dev_model.setup_q,
         u_adc_dev_model.config_q}, {15'h0, h, se, ce});
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (k >= 64) begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    s = hrdata;
  endtask

  // issue a command and poll until the link is no longer busy
  task automatic run(input logic [31:0] c, input logic [7:0] b);
    int n;
    xfer(`OFS_CMD, 1'b1, c | (32'(b) << `CMD_DATA_LSB));
    n = 0;
    do begin
      xfer(`OFS_STATUS, 1'b0, 32'h0000_0000);
      n++;
    end while (s[`STS_BUSY] !== 1'b0 && n < 10000);
    if (n >= 10000) begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic t_reset();
    xfer(`OFS_STATUS, 1'b0, 32'h0000_0000);
    cks(32'h0000_0000);
    xfer(32'h0000_0010, 1'b1, 32'hffff_ffff);
    xfer(32'h0000_0010, 1'b0, 32'h0000_0000);
    chk(s, 32'h0000_0000);
    chk({30'h0, scl, sda}, 32'h0000_0003);
    chk({28'h0, hresp, hreadyout, scl_o, sda_o}, 32'h0000_0004);
    ckd(1'b0, 8'h00, 8'h01);
    $display("t_reset done");
  endtask

  task automatic t_write();
    run(OP_S | OP_W, AW);
    cks(SB_AC);
    run(OP_W, 8'h3c);
    ckd(1'b0, 8'h00, 8'h3c);
    run(OP_W | OP_P, 8'hf7);
    ckd(1'b0, 8'hf7, 8'h3c);
    cks(32'h0000_0000);
    chk({30'h0, scl, sda}, 32'h0000_0003);
    run(OP_S | OP_W, AW);
    run(OP_W | OP_P, 8'hc8);
    ckd(1'b0, 8'hc8, 8'h01);
    xfer(`OFS_CMD, 1'b0, 32'h0000_0000);
    chk(s, 32'h0000_c800);
    $display("t_write done");
  endtask

  task automatic t_read();
    run(OP_S | OP_W, {DEV_ADDR, 1'b1});
    cks(SB_AC);
    run(OP_R, 8'h00);
    chk(s & 32'h0000_ff04, 32'h0000_c804);
    run(OP_R | OP_N | OP_P, 8'h00);
    chk(s & 32'h0000_ff04, 32'h0000_c800);
    $display("t_read done");
  endtask

  task automatic t_bad_addr();
    run(OP_S | OP_W | OP_P, 8'h22);
    cks(SB_NK | SB_AB);
    ckd(1'b0, 8'hc8, 8'h01);
    xfer(`OFS_STATUS, 1'b1, SB_NK | SB_AB);
    run(OP_P, 8'h00);
    cks(32'h0000_0000);
    chk({30'h0, scl, sda}, 32'h0000_0003);
    $display("t_bad_addr done");
  endtask

  task automatic t_hs();
    run(OP_H | OP_W, AW);
    cks(SB_HS | SB_AC);
    ckd(1'b1, 8'hc8, 8'h01);
    run(OP_W, 8'ha6);
    ckd(1'b1, 8'ha6, 8'h01);
    run(OP_S | OP_W, AW);
    cks(SB_HS | SB_AC);
    ckd(1'b1, 8'ha6, 8'h01);
    run(OP_P, 8'h00);
    cks(32'h0000_0000);
    ckd(1'b0, 8'ha6, 8'h01);
    $display("t_hs done");
  endtask

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_write();
    t_read();
    t_bad_addr();
    t_hs();
    test_done();
  end
endmodule  // adc_link_master_tb
`default_nettype wire
